// file: core/dmac_channel.sv
// one double-buffered dma channel with an axi4-lite register slave
//
// Added by the designer: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
module dmac_channel #(
   parameter logic [31:0] RSV_LO = 32'hF000_0000,
   parameter logic [31:0] RSV_HI = 32'hFFFF_FFFF
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [15:0] dev_req,
   output logic bus_req,
   input wire logic bus_grant,
   output logic beat_valid,
   output dmac_pkg::dmac_beat_s beat,
   input wire logic beat_ready,
   output logic chan_irq
);

   // ---------------------------------------------------------------
   // storage
   // ---------------------------------------------------------------
   localparam int unsigned CSR_LAST = dmac_pkg::CSR_W - 1;
   logic [CSR_LAST:0] csr;
   logic [CSR_LAST:0] next_csr;
   logic [31:0] target;
   logic [31:0] sa_a;
   logic [31:0] sa_b;
   logic [dmac_pkg::TC_W-1:0] tc_a;
   logic [dmac_pkg::TC_W-1:0] tc_b;
   dmac_pkg::dmac_state_e state;
   logic [3:0] beat_cnt;

   // axi holding registers
   logic aw_held;
   logic [7:0] aw_addr_q;
   logic w_held;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic wr_fire;
   logic wr_hit;
   logic rd_hit;
   logic [31:0] rd_word;

   // engine terms
   logic sel_b;
   logic cur_go;
   logic [31:0] cur_sa;
   logic [dmac_pkg::TC_W-1:0] cur_tc;
   logic [dmac_pkg::TC_W-1:0] step;
   logic [3:0] burst_len;
   logic dev_sel;
   logic in_rsv;
   logic beat_take;
   logic last_byte;
   logic fin_now;
   logic fin_a;
   logic fin_b;
   logic hw_err;
   logic set_wr;
   logic clr_wr;
   logic [7:0] wd;

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction : merge

   function automatic logic known_off(input logic [7:0] a);
      logic r;
      r = (a == dmac_pkg::OFF_TARGET) || (a == dmac_pkg::OFF_CSR_SET) ||
          (a == dmac_pkg::OFF_CSR_CLR) || (a == dmac_pkg::OFF_CSR_RO) ||
          (a == dmac_pkg::OFF_SA_A) || (a == dmac_pkg::OFF_TC_A) ||
          (a == dmac_pkg::OFF_SA_B) || (a == dmac_pkg::OFF_TC_B);
      return r;
   endfunction : known_off

   // ---------------------------------------------------------------
   // axi4-lite write channel
   // ---------------------------------------------------------------
   assign s_axi_awready = ce && !aw_held && !s_axi_bvalid;
   assign s_axi_wready = ce && !w_held && !s_axi_bvalid;
   assign wr_fire = ce && aw_held && w_held;
   assign wr_hit = known_off(aw_addr_q);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         aw_addr_q <= 8'h00;
      end else if (ce) begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end else if (wr_fire) begin
            aw_held <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held <= 1'b0;
         w_data_q <= dmac_pkg::WORD_RST;
         w_strb_q <= 4'h0;
      end else if (ce) begin
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end else if (wr_fire) begin
            w_held <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= dmac_pkg::RESP_OKAY;
      end else if (ce) begin
         if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? dmac_pkg::RESP_OKAY : dmac_pkg::RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // axi4-lite read channel
   // ---------------------------------------------------------------
   assign s_axi_arready = ce && !s_axi_rvalid;
   assign rd_hit = known_off(s_axi_araddr);

   always_comb begin
      rd_word = dmac_pkg::WORD_RST;
      case (s_axi_araddr)
         dmac_pkg::OFF_TARGET: rd_word = target;
         dmac_pkg::OFF_CSR_SET, dmac_pkg::OFF_CSR_CLR, dmac_pkg::OFF_CSR_RO: begin
            rd_word = {24'h000000, csr};
         end
         dmac_pkg::OFF_SA_A: rd_word = sa_a;
         dmac_pkg::OFF_TC_A: rd_word = {19'h00000, tc_a};
         dmac_pkg::OFF_SA_B: rd_word = sa_b;
         dmac_pkg::OFF_TC_B: rd_word = {19'h00000, tc_b};
         default: rd_word = dmac_pkg::WORD_RST;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= dmac_pkg::WORD_RST;
         s_axi_rresp <= dmac_pkg::RESP_OKAY;
      end else if (ce) begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_hit ? dmac_pkg::RESP_OKAY : dmac_pkg::RESP_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // engine terms
   // ---------------------------------------------------------------
   assign sel_b = csr[dmac_pkg::BIT_BIU];
   assign cur_go = sel_b ? csr[dmac_pkg::BIT_GO_B] : csr[dmac_pkg::BIT_GO_A];
   assign cur_sa = sel_b ? sa_b : sa_a;
   assign cur_tc = sel_b ? tc_b : tc_a;
   assign step = target[dmac_pkg::TGT_HALF] ? 13'h0002 : 13'h0001;
   assign burst_len = target[dmac_pkg::TGT_BURST8] ? dmac_pkg::BEATS_LONG : dmac_pkg::BEATS_SHORT;
   assign dev_sel = dev_req[target[dmac_pkg::TGT_SEL_LO +: dmac_pkg::SEL_W]];
   assign in_rsv = (cur_sa >= RSV_LO) && (cur_sa <= RSV_HI);
   assign beat_take = ce && beat_valid && beat_ready;
   assign last_byte = cur_tc <= step;
   assign hw_err = ce && (state == dmac_pkg::ST_IDLE) && csr[dmac_pkg::BIT_RUN] && cur_go &&
                   (cur_tc != dmac_pkg::TC_RST) && in_rsv;
   assign fin_now = (beat_take && last_byte) ||
                    (ce && (state == dmac_pkg::ST_IDLE) && csr[dmac_pkg::BIT_RUN] && cur_go &&
                     (cur_tc == dmac_pkg::TC_RST));
   assign fin_a = fin_now && !sel_b;
   assign fin_b = fin_now && sel_b;

   assign beat_valid = ce && (state == dmac_pkg::ST_BURST);
   assign bus_req = (state == dmac_pkg::ST_WAIT) || (state == dmac_pkg::ST_BURST);
   assign beat.addr = cur_sa;
   assign beat.to_mem = target[dmac_pkg::TGT_DIR];
   assign beat.half = target[dmac_pkg::TGT_HALF];
   assign beat.big_endian = target[dmac_pkg::TGT_BIG];

   // ---------------------------------------------------------------
   // channel sequencer
   // ---------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state <= dmac_pkg::ST_IDLE;
         beat_cnt <= 4'h0;
      end else if (ce) begin
         case (state)
            dmac_pkg::ST_IDLE: begin
               if (csr[dmac_pkg::BIT_RUN] && cur_go && !fin_now && !in_rsv && dev_sel) begin
                  state <= dmac_pkg::ST_WAIT;
               end
            end
            dmac_pkg::ST_WAIT: begin
               if (!csr[dmac_pkg::BIT_RUN]) begin
                  state <= dmac_pkg::ST_IDLE;
               end else if (bus_grant) begin
                  state <= dmac_pkg::ST_BURST;
                  beat_cnt <= 4'h0;
               end
            end
            dmac_pkg::ST_BURST: begin
               if (beat_take) begin
                  beat_cnt <= beat_cnt + 4'h1;
                  // run is not looked at here, so a pause waits for the burst end
                  if (last_byte || (beat_cnt == burst_len - 4'h1)) begin
                     state <= dmac_pkg::ST_IDLE;
                  end
               end
            end
            default: state <= dmac_pkg::ST_IDLE;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // pointers and counts
   // ---------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sa_a <= dmac_pkg::WORD_RST;
         tc_a <= dmac_pkg::TC_RST;
      end else if (ce) begin
         if (beat_take && !sel_b) begin
            sa_a <= sa_a + {19'h00000, step};
            tc_a <= last_byte ? dmac_pkg::TC_RST : tc_a - step;
         end else if (wr_fire && aw_addr_q == dmac_pkg::OFF_SA_A) begin
            sa_a <= merge(sa_a, w_data_q, w_strb_q);
         end else if (wr_fire && aw_addr_q == dmac_pkg::OFF_TC_A) begin
            tc_a <= 13'(merge({19'h00000, tc_a}, w_data_q, w_strb_q));
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sa_b <= dmac_pkg::WORD_RST;
         tc_b <= dmac_pkg::TC_RST;
      end else if (ce) begin
         if (beat_take && sel_b) begin
            sa_b <= sa_b + {19'h00000, step};
            tc_b <= last_byte ? dmac_pkg::TC_RST : tc_b - step;
         end else if (wr_fire && aw_addr_q == dmac_pkg::OFF_SA_B) begin
            sa_b <= merge(sa_b, w_data_q, w_strb_q);
         end else if (wr_fire && aw_addr_q == dmac_pkg::OFF_TC_B) begin
            tc_b <= 13'(merge({19'h00000, tc_b}, w_data_q, w_strb_q));
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         target <= dmac_pkg::WORD_RST;
      end else if (ce && wr_fire && aw_addr_q == dmac_pkg::OFF_TARGET) begin
         target <= merge(target, w_data_q, w_strb_q);
      end
   end

   // ---------------------------------------------------------------
   // control/status bits
   // ---------------------------------------------------------------
   assign wd = w_strb_q[0] ? w_data_q[7:0] : 8'h00;
   assign set_wr = wr_fire && (aw_addr_q == dmac_pkg::OFF_CSR_SET);
   assign clr_wr = wr_fire && (aw_addr_q == dmac_pkg::OFF_CSR_CLR);

   always_comb begin
      next_csr = csr;
      if (set_wr) begin
         next_csr[dmac_pkg::BIT_RUN] = csr[dmac_pkg::BIT_RUN] | wd[dmac_pkg::BIT_RUN];
         next_csr[dmac_pkg::BIT_IE] = csr[dmac_pkg::BIT_IE] | wd[dmac_pkg::BIT_IE];
         next_csr[dmac_pkg::BIT_GO_A] = csr[dmac_pkg::BIT_GO_A] | wd[dmac_pkg::BIT_GO_A];
         next_csr[dmac_pkg::BIT_GO_B] = csr[dmac_pkg::BIT_GO_B] | wd[dmac_pkg::BIT_GO_B];
         if (wd[dmac_pkg::BIT_RUN]) begin
            next_csr[dmac_pkg::BIT_ERR] = 1'b0;
         end
         if (wd[dmac_pkg::BIT_GO_A]) begin
            next_csr[dmac_pkg::BIT_DONE_A] = 1'b0;
         end
         if (wd[dmac_pkg::BIT_GO_B]) begin
            next_csr[dmac_pkg::BIT_DONE_B] = 1'b0;
         end
      end
      if (clr_wr) begin
         if (wd[dmac_pkg::BIT_RUN]) next_csr[dmac_pkg::BIT_RUN] = 1'b0;
         if (wd[dmac_pkg::BIT_IE]) next_csr[dmac_pkg::BIT_IE] = 1'b0;
         if (wd[dmac_pkg::BIT_DONE_A]) next_csr[dmac_pkg::BIT_DONE_A] = 1'b0;
         if (wd[dmac_pkg::BIT_DONE_B]) next_csr[dmac_pkg::BIT_DONE_B] = 1'b0;
         if (wd[dmac_pkg::BIT_GO_A]) next_csr[dmac_pkg::BIT_GO_A] = 1'b0;
         if (wd[dmac_pkg::BIT_GO_B]) next_csr[dmac_pkg::BIT_GO_B] = 1'b0;
      end
      // hardware events last, so they win over a software set or clear in the same cycle
      if (hw_err) begin
         next_csr[dmac_pkg::BIT_ERR] = 1'b1;
         next_csr[dmac_pkg::BIT_RUN] = 1'b0;
      end
      if (fin_a) begin
         next_csr[dmac_pkg::BIT_DONE_A] = 1'b1;
         next_csr[dmac_pkg::BIT_GO_A] = 1'b0;
      end
      if (fin_b) begin
         next_csr[dmac_pkg::BIT_DONE_B] = 1'b1;
         next_csr[dmac_pkg::BIT_GO_B] = 1'b0;
      end
      if (fin_now) begin
         next_csr[dmac_pkg::BIT_BIU] = ~csr[dmac_pkg::BIT_BIU];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         csr <= dmac_pkg::CSR_RST;
      end else if (ce) begin
         csr <= next_csr;
      end
   end

   assign chan_irq = csr[dmac_pkg::BIT_IE] && (csr[dmac_pkg::BIT_DONE_A] ||
                     csr[dmac_pkg::BIT_DONE_B] || csr[dmac_pkg::BIT_ERR]);

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   paused_no_burst_a: assert property (ce && state != dmac_pkg::ST_BURST && !csr[dmac_pkg::BIT_RUN]
      |=> state != dmac_pkg::ST_BURST) else $error("burst started with run clear");
   burst_completes_a: assert property (ce && state == dmac_pkg::ST_BURST && !csr[dmac_pkg::BIT_RUN]
      && !(beat_take && (last_byte || beat_cnt == burst_len - 4'h1))
      |=> state == dmac_pkg::ST_BURST) else $error("burst cut short by pause");
   irq_on_done_a: assert property (fin_a && csr[dmac_pkg::BIT_IE] && !clr_wr
      |=> chan_irq) else $error("interrupt missing after done");
   irq_drop_a: assert property (clr_wr && wd[dmac_pkg::BIT_DONE_A] && wd[dmac_pkg::BIT_DONE_B]
      && !csr[dmac_pkg::BIT_ERR] && !fin_now && !hw_err |=> !chan_irq) else $error("interrupt stuck");
   err_clear_a: assert property (set_wr && wd[dmac_pkg::BIT_RUN] && !hw_err
      |=> !csr[dmac_pkg::BIT_ERR]) else $error("error not cleared by run");
   done_a_set_a: assert property (fin_a |=> csr[dmac_pkg::BIT_DONE_A] &&
      !csr[dmac_pkg::BIT_GO_A]) else $error("buffer A finish not recorded");
   done_b_set_a: assert property (fin_b |=> csr[dmac_pkg::BIT_DONE_B] &&
      !csr[dmac_pkg::BIT_GO_B]) else $error("buffer B finish not recorded");
   biu_toggle_a: assert property (fin_now |=> csr[dmac_pkg::BIT_BIU] != $past(csr[dmac_pkg::BIT_BIU]))
      else $error("active buffer did not toggle");
   biu_hold_a: assert property (!fin_now |=> $stable(csr[dmac_pkg::BIT_BIU]))
      else $error("active buffer changed without a finish");
   ptr_step_a: assert property (beat_take && !sel_b |=> sa_a == $past(sa_a) + {19'h00000, $past(step)})
      else $error("buffer A pointer did not advance");

   finish_a_c: cover property (fin_a && state == dmac_pkg::ST_BURST);
   finish_b_c: cover property (fin_b && state == dmac_pkg::ST_BURST);
   pause_mid_c: cover property (state == dmac_pkg::ST_BURST && !csr[dmac_pkg::BIT_RUN]);
   error_c: cover property (hw_err);

endmodule : dmac_channel

// file: common/dmac_pkg.sv
// shared constants and types for the double-buffered dma channel
package dmac_pkg;

   // ---------------------------------------------------------------
   // register byte offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] OFF_TARGET = 8'h00;
   localparam logic [7:0] OFF_CSR_SET = 8'h04;
   localparam logic [7:0] OFF_CSR_CLR = 8'h08;
   localparam logic [7:0] OFF_CSR_RO = 8'h0C;
   localparam logic [7:0] OFF_SA_A = 8'h10;
   localparam logic [7:0] OFF_TC_A = 8'h14;
   localparam logic [7:0] OFF_SA_B = 8'h18;
   localparam logic [7:0] OFF_TC_B = 8'h1C;

   // ---------------------------------------------------------------
   // control/status field positions
   // ---------------------------------------------------------------
   localparam int unsigned CSR_W = 8;
   localparam int unsigned BIT_RUN = 0;
   localparam int unsigned BIT_IE = 1;
   localparam int unsigned BIT_ERR = 2;
   localparam int unsigned BIT_DONE_A = 3;
   localparam int unsigned BIT_GO_A = 4;
   localparam int unsigned BIT_DONE_B = 5;
   localparam int unsigned BIT_GO_B = 6;
   localparam int unsigned BIT_BIU = 7;

   // ---------------------------------------------------------------
   // peripheral target register fields
   // ---------------------------------------------------------------
   localparam int unsigned TGT_DIR = 0;
   localparam int unsigned TGT_BIG = 1;
   localparam int unsigned TGT_BURST8 = 2;
   localparam int unsigned TGT_HALF = 3;
   localparam int unsigned TGT_SEL_LO = 4;
   localparam int unsigned SEL_W = 4;

   // ---------------------------------------------------------------
   // widths, reset values, burst lengths, responses
   // ---------------------------------------------------------------
   localparam int unsigned TC_W = 13;
   localparam logic [CSR_W-1:0] CSR_RST = 8'h00;
   localparam logic [TC_W-1:0] TC_RST = 13'h0000;
   localparam logic [31:0] WORD_RST = 32'h0000_0000;
   localparam logic [3:0] BEATS_SHORT = 4'h4;
   localparam logic [3:0] BEATS_LONG = 4'h8;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_BURST} dmac_state_e;

   // one memory beat offered to the memory port
   typedef struct packed {
      logic [31:0] addr;
      logic to_mem;
      logic half;
      logic big_endian;
   } dmac_beat_s;

endpackage : dmac_pkg

// file: test/dmac_far_model.sv
// far-side model: request lines, grant and memory acceptor
`timescale 1ns/1ps
module dmac_far_model (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic req_on,
   input wire logic [3:0] req_idx,
   input wire logic slow,
   input wire logic bus_req,
   input wire logic beat_valid,
   output logic [15:0] dev_req,
   output logic bus_grant,
   output logic beat_ready
);
   // one request line per select code
   assign dev_req = req_on ? (16'h0001 << req_idx) : 16'h0000;
   // lone channel wins one cycle after asking
   always_ff @(posedge aclk) begin
      if (!aresetn) bus_grant <= 1'h0;
      else bus_grant <= bus_req;
   end
   // slow memory stalls every other cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) beat_ready <= 1'h0;
      else beat_ready <= slow ? !beat_ready : 1'h1;
   end
endmodule : dmac_far_model

// file: test/dmac_channel_tb_top.sv
// self-checking bench for the dma channel
`timescale 1ns/1ps
module dmac_channel_tb_top;
   logic aclk = 1'h0, aresetn = 1'h0, ce = 1'h1;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, last_addr = 32'h0, rd;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, rs;
   logic [15:0] dev_req;
   logic bus_req, bus_grant, beat_valid, beat_ready, chan_irq;
   dmac_pkg::dmac_beat_s beat;
   logic req_on = 1'h0, slow = 1'h0;
   logic [3:0] req_idx = 4'h3;
   int num_errors = 0, n_checks = 0, nb = 0;
   typedef struct {logic [7:0] wa; logic [31:0] wd; logic [7:0] ra; logic [31:0] ex; logic [1:0] rsp;} dmac_row_s;
   dmac_row_s rows [7] = '{
      '{dmac_pkg::OFF_TC_A, 32'hFFFF_FFFF, dmac_pkg::OFF_TC_A, 32'h0000_1FFF, 2'h0},
      '{dmac_pkg::OFF_TC_B, 32'hFFFF_0005, dmac_pkg::OFF_TC_B, 32'h0000_0005, 2'h0},
      '{dmac_pkg::OFF_SA_A, 32'h1234_ABCD, dmac_pkg::OFF_SA_A, 32'h1234_ABCD, 2'h0},
      '{dmac_pkg::OFF_SA_B, 32'h89AB_CDEF, dmac_pkg::OFF_SA_B, 32'h89AB_CDEF, 2'h0},
      '{dmac_pkg::OFF_CSR_SET, 32'hFFFF_FF02, dmac_pkg::OFF_CSR_RO, 32'h0000_0002, 2'h0},
      '{dmac_pkg::OFF_CSR_CLR, 32'h0000_0002, dmac_pkg::OFF_CSR_SET, 32'h0000_0000, 2'h0},
      '{8'h20, 32'hFFFF_FFFF, 8'h20, 32'h0000_0000, 2'h2}};

   dmac_channel dmac_channel_i (.*);
   dmac_far_model dmac_far_model_i (.*);

   always #2.5 aclk = !aclk;
   always @(posedge aclk) begin
      if (beat_valid && beat_ready) begin
         nb <= nb + 1;
         last_addr <= beat.addr;
      end
   end

   // ----
   // checks and bus cycles
   // ----
   task automatic report_and_stop;
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : report_and_stop
   task automatic chk_word(input string nm, input logic [31:0] ex, input logic [31:0] got);
      n_checks++;
      if (got !== ex) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", nm, ex, got);
      end
   endtask : chk_word
   task automatic tmo(input int k);
      if (k >= 400) begin
         num_errors++;
         report_and_stop();
      end
   endtask : tmo
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      int k;
      logic ta, tw, tb;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      tb = 1'h0;
      for (k = 0; k < 400 && !tb; k++) begin
         @(negedge aclk);
         ta = s_axi_awvalid && s_axi_awready;
         tw = s_axi_wvalid && s_axi_wready;
         tb = s_axi_bvalid;
         r = s_axi_bresp;
         @(posedge aclk);
         if (ta) s_axi_awvalid <= 1'h0;
         if (tw) s_axi_wvalid <= 1'h0;
      end
      tmo(k);
   endtask : axi_wr
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int k;
      logic ta, tr;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      tr = 1'h0;
      for (k = 0; k < 400 && !tr; k++) begin
         @(negedge aclk);
         ta = s_axi_arvalid && s_axi_arready;
         tr = s_axi_rvalid;
         d = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge aclk);
         if (ta) s_axi_arvalid <= 1'h0;
      end
      tmo(k);
   endtask : axi_rd
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [1:0] r;
      axi_wr(a, d, r);
   endtask : wr
   task automatic rchk(input logic [7:0] a, input logic [31:0] ex);
      logic [31:0] d;
      logic [1:0] r;
      axi_rd(a, d, r);
      chk_word("csr or count", ex, d);
   endtask : rchk
   task automatic wait_nb(input int n);
      int k;
      for (k = 0; k < 400 && nb < n; k++) @(posedge aclk);
      tmo(k);
   endtask : wait_nb
   task automatic wait_beats(input int n);
      wait_nb(n);
      repeat (4) @(posedge aclk);
   endtask : wait_beats

   // ----
   // main sequence
   // ----
   initial begin
      repeat (3) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
      rchk(dmac_pkg::OFF_CSR_RO, 32'h0);
      foreach (rows[i]) begin
         axi_wr(rows[i].wa, rows[i].wd, rs);
         chk_word("bresp", {30'h0, rows[i].rsp}, {30'h0, rs});
         axi_rd(rows[i].ra, rd, rs);
         chk_word("rdata", rows[i].ex, rd);
         chk_word("rresp", {30'h0, rows[i].rsp}, {30'h0, rs});
      end
      wr(dmac_pkg::OFF_TARGET, 32'h0000_0030);
      wr(dmac_pkg::OFF_SA_A, 32'h0000_1000);
      wr(dmac_pkg::OFF_TC_A, 32'h0000_0006);
      req_on <= 1'h1;
      wr(dmac_pkg::OFF_CSR_SET, 32'h0000_0012);
      repeat (20) @(posedge aclk);
      chk_word("beats", 32'h0, nb);
      req_idx <= 4'h5;
      wr(dmac_pkg::OFF_CSR_SET, 32'h0000_0001);
      repeat (20) @(posedge aclk);
      chk_word("beats", 32'h0, nb);
      req_idx <= 4'h3;
      wait_beats(6);
      chk_word("beats", 32'h6, nb);
      chk_word("last addr", 32'h0000_1005, last_addr);
      rchk(dmac_pkg::OFF_CSR_RO, 32'h8B);
      rchk(dmac_pkg::OFF_TC_A, 32'h0);
      chk_word("irq", 32'h1, chan_irq);
      wr(dmac_pkg::OFF_CSR_CLR, 32'h0000_0028);
      rchk(dmac_pkg::OFF_CSR_RO, 32'h83);
      chk_word("irq", 32'h0, chan_irq);
      slow <= 1'h1;
      wr(dmac_pkg::OFF_SA_B, 32'h0000_2000);
      wr(dmac_pkg::OFF_TC_B, 32'h0000_0002);
      wr(dmac_pkg::OFF_CSR_SET, 32'h0000_0040);
      wait_beats(8);
      chk_word("last addr", 32'h0000_2001, last_addr);
      rchk(dmac_pkg::OFF_CSR_RO, 32'h23);
      wr(dmac_pkg::OFF_CSR_CLR, 32'h0000_0020);
      wr(dmac_pkg::OFF_SA_A, 32'hF000_0000);
      wr(dmac_pkg::OFF_TC_A, 32'h0000_0004);
      wr(dmac_pkg::OFF_CSR_SET, 32'h0000_0010);
      repeat (10) @(posedge aclk);
      rchk(dmac_pkg::OFF_CSR_RO, 32'h16);
      chk_word("beats", 32'h8, nb);
      chk_word("irq", 32'h1, chan_irq);
      wr(dmac_pkg::OFF_CSR_CLR, 32'h0000_0010);
      wr(dmac_pkg::OFF_CSR_SET, 32'h0000_0001);
      rchk(dmac_pkg::OFF_CSR_RO, 32'h03);
      // pause in mid-burst, then resume from the pointer
      wr(dmac_pkg::OFF_SA_A, 32'h0000_3000);
      wr(dmac_pkg::OFF_TC_A, 32'h0000_0008);
      wr(dmac_pkg::OFF_CSR_SET, 32'h0000_0010);
      wait_nb(9);
      wr(dmac_pkg::OFF_CSR_CLR, 32'h0000_0001);
      repeat (20) @(posedge aclk);
      chk_word("beats", 32'hC, nb);
      rchk(dmac_pkg::OFF_TC_A, 32'h4);
      wr(dmac_pkg::OFF_CSR_SET, 32'h0000_0001);
      wait_beats(16);
      chk_word("last addr", 32'h0000_3007, last_addr);
      rchk(dmac_pkg::OFF_CSR_RO, 32'h8B);
      // both go bits at once: active buffer b goes first
      wr(dmac_pkg::OFF_SA_B, 32'h0000_4000);
      wr(dmac_pkg::OFF_TC_B, 32'h0000_0001);
      wr(dmac_pkg::OFF_SA_A, 32'h0000_5000);
      wr(dmac_pkg::OFF_TC_A, 32'h0000_0001);
      wr(dmac_pkg::OFF_CSR_SET, 32'h0000_0050);
      wait_nb(17);
      chk_word("first addr", 32'h0000_4000, last_addr);
      wait_beats(18);
      chk_word("last addr", 32'h0000_5000, last_addr);
      rchk(dmac_pkg::OFF_CSR_RO, 32'hAB);
      // reset in mid-run clears the active buffer bit
      aresetn <= 1'h0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
      rchk(dmac_pkg::OFF_CSR_RO, 32'h0);
      chk_word("irq", 32'h0, chan_irq);
      report_and_stop();
   end
endmodule : dmac_channel_tb_top
